/* File: logic/opamp_pin_share_defs.svh */
// Purpose: Constants for the amplifier pin-sharing control block.
// Assumes: Registers sit on a 32-bit AHB-Lite bus, one aligned word each.
// Notes: Register byte address is four times the register index.
`ifndef OPAMP_PIN_SHARE_DEFS_SVH
`define OPAMP_PIN_SHARE_DEFS_SVH

// ==========================================================================
// Register map.
`define AMP_MODE_IDX 12'h09b
`define PORT1_CFG_IDX 12'h0d6
`define AMP_MODE_RESET 8'h00
`define PORT1_CFG_RESET 8'h00
`define PORT1_CFG_WMASK 8'hfe
`define AMP_EN_BIT 0

// ==========================================================================
// Pin positions and ADC routing.
`define AMP_OUT_PIN 3
`define AMP_POS_PIN 4
`define AMP_NEG_PIN 5
`define AMP_PIN_MASK 8'h38
`define ADC_AMP_CHANNEL 4'hb

`endif

/* File: logic/opamp_pin_share_pkg.sv */
// Purpose: Types for the amplifier pin-sharing control block.
// Assumes: Port 1 is eight pins wide.
// Notes: Constants live in the defs header.
package opamp_pin_share_pkg;
   typedef logic [7:0] port_mask_t;
   typedef logic [3:0] adc_channel_t;
   typedef enum logic [1:0] {
      REG_NONE = 2'b00,
      REG_MODE = 2'b01,
      REG_CFG = 2'b10
   } reg_sel_t;
endpackage

/* File: logic/pad_input_sync.sv */
// Purpose: Two-stage synchroniser for pad input levels.
// Assumes: Inputs are asynchronous to ref_clk_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module pad_input_sync (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] async_in,
   output logic [7:0] sync_out
);
   logic [7:0] meta_q;

   // ==========================================================================
   // Both stages reset to zero and shift every clock.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q <= 8'h00;
         sync_out <= 8'h00;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* File: logic/opamp_pin_share_control.sv */
// Purpose: Switches port-1 pins between GPIO, amplifier and pure analog use.
// Assumes: Port logic and ADC selector run on ref_clk_in; pad inputs do not.
// Notes: All outputs are registered, so pin changes follow register state by one clock.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "opamp_pin_share_defs.svh"
module opamp_pin_share_control (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [7:0] gpio_dout_in,
   input wire logic [7:0] gpio_drive_in,
   input wire logic [7:0] pad_din_in,
   input wire logic [3:0] adc_channel_select_in,
   output logic [7:0] pad_dout_out,
   output logic [7:0] pad_oe_n_out,
   output logic [7:0] gpio_din_out,
   output logic [7:0] pad_analog_out,
   output logic amp_enable_out,
   output logic amp_output_pin_out,
   output logic amp_positive_pin_out,
   output logic amp_negative_pin_out,
   output logic adc_amp_channel_out
);
   logic amp_en_q;
   logic amp_en_d;
   opamp_pin_share_pkg::port_mask_t cfg_q;
   opamp_pin_share_pkg::port_mask_t cfg_d;
   opamp_pin_share_pkg::reg_sel_t wr_sel_q;
   opamp_pin_share_pkg::port_mask_t pad_sync;
   opamp_pin_share_pkg::port_mask_t digital_off;
   logic take;

   // ==========================================================================
   // Register decode, used for both the read and the write path.
   function automatic opamp_pin_share_pkg::reg_sel_t reg_decode(input logic [31:0] addr);
      if (addr[13:2] == `AMP_MODE_IDX) begin
         reg_decode = opamp_pin_share_pkg::REG_MODE;
      end else if (addr[13:2] == `PORT1_CFG_IDX) begin
         reg_decode = opamp_pin_share_pkg::REG_CFG;
      end else begin
         reg_decode = opamp_pin_share_pkg::REG_NONE;
      end
   endfunction

   // ==========================================================================
   // Pad inputs cross into the clock domain before any gating.
   pad_input_sync u_pad_sync (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(pad_din_in),
      .sync_out(pad_sync)
   );

   // ==========================================================================
   // Bus slave: an address phase is taken when selected, active and ready.
   assign take = hsel_in && htrans_in[1] && hready_in;

   // Write target is remembered for the following data phase.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_sel_q <= opamp_pin_share_pkg::REG_NONE;
      end else if (hready_in) begin
         wr_sel_q <= (take && hwrite_in) ? reg_decode(haddr_in) : opamp_pin_share_pkg::REG_NONE;
      end
   end

   // Next register values; data-phase writes land here.
   always_comb begin
      amp_en_d = amp_en_q;
      cfg_d = cfg_q;
      if (wr_sel_q == opamp_pin_share_pkg::REG_MODE) begin
         amp_en_d = hwdata_in[`AMP_EN_BIT];
      end
      if (wr_sel_q == opamp_pin_share_pkg::REG_CFG) begin
         cfg_d = hwdata_in[7:0] & `PORT1_CFG_WMASK;
      end
   end

   // Enable and config registers; enable clears at reset so pins start as GPIO.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         amp_en_q <= 1'b0;
         cfg_q <= `PORT1_CFG_RESET;
      end else begin
         amp_en_q <= amp_en_d;
         cfg_q <= cfg_d;
      end
   end

   // Read data is captured at the address phase from next values, so a read right after a
   // write returns the new value. Unmapped addresses and reserved bits read zero.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (take && !hwrite_in) begin
         case (reg_decode(haddr_in))
            opamp_pin_share_pkg::REG_MODE: hrdata_out <= {31'h0000_0000, amp_en_d};
            opamp_pin_share_pkg::REG_CFG: hrdata_out <= {24'h00_0000, cfg_d};
            default: hrdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // The slave never waits and always answers OKAY.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // ==========================================================================
   // Pin ownership: a pin loses its digital path if its config bit is set or the amplifier owns it.
   assign digital_off = cfg_q | (amp_en_q ? `AMP_PIN_MASK : 8'h00);

   // Pad drivers and digital input gating, one bit per pin.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pad_dout_out <= 8'h00;
         pad_oe_n_out <= 8'hff;
         gpio_din_out <= 8'h00;
         pad_analog_out <= 8'h00;
      end else begin
         pad_dout_out <= gpio_dout_in & ~digital_off;
         pad_oe_n_out <= ~(gpio_drive_in & ~digital_off);
         gpio_din_out <= pad_sync & ~digital_off;
         pad_analog_out <= digital_off;
      end
   end

   // Amplifier terminals and the ADC route of its output.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         amp_enable_out <= 1'b0;
         amp_output_pin_out <= 1'b0;
         amp_positive_pin_out <= 1'b0;
         amp_negative_pin_out <= 1'b0;
         adc_amp_channel_out <= 1'b0;
      end else begin
         amp_enable_out <= amp_en_q;
         amp_output_pin_out <= amp_en_q;
         amp_positive_pin_out <= amp_en_q;
         amp_negative_pin_out <= amp_en_q;
         adc_amp_channel_out <= amp_en_q && (adc_channel_select_in == `ADC_AMP_CHANNEL);
      end
   end

   // ==========================================================================
   // Checks on pin ownership and register behaviour.
   // Antecedents that would otherwise always hold also sample reset. The edge that releases reset
   // still leaves the outputs at their reset values, so no check may start there.
   property p_gpio_when_off;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (!amp_en_q && cfg_q[5:3] == 3'b000) |=> (pad_analog_out[5:3] == 3'b000 && !amp_output_pin_out);
   endproperty
   a_gpio_when_off: assert property (p_gpio_when_off) else $error("Pins 3..5 not GPIO while amp off.");

   property p_isolate_when_on;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      amp_en_q |=> (pad_oe_n_out[5:3] == 3'b111 && gpio_din_out[5:3] == 3'b000 && pad_dout_out[5:3] == 3'b000);
   endproperty
   a_isolate_when_on: assert property (p_isolate_when_on) else $error("GPIO path open while amp on.");

   property p_pin_map;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      amp_en_q |=> (pad_analog_out[`AMP_OUT_PIN] && amp_output_pin_out && pad_analog_out[`AMP_POS_PIN]
                    && amp_positive_pin_out && pad_analog_out[`AMP_NEG_PIN] && amp_negative_pin_out);
   endproperty
   a_pin_map: assert property (p_pin_map) else $error("Amp terminals not on pins 3, 4, 5.");

   property p_adc_route;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      reset_n_in |=> (adc_amp_channel_out == ($past(amp_en_q) && $past(adc_channel_select_in) == 4'hb));
   endproperty
   a_adc_route: assert property (p_adc_route) else $error("Amp to ADC route wrong.");

   property p_pure_analog;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      reset_n_in |=> ((pad_oe_n_out[5:3] & $past(cfg_q[5:3])) == $past(cfg_q[5:3])
                && (gpio_din_out[5:3] & $past(cfg_q[5:3])) == 3'b000);
   endproperty
   a_pure_analog: assert property (p_pure_analog) else $error("Pure analog pin kept digital path.");

   property p_gpio_allowed;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (reset_n_in && !amp_en_q && !cfg_q[3] && gpio_drive_in[3])
      |=> (!pad_oe_n_out[3] && pad_dout_out[3] == $past(gpio_dout_in[3]));
   endproperty
   a_gpio_allowed: assert property (p_gpio_allowed) else $error("Pin 3 not driven as GPIO.");

   property p_enable_write;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (take && hwrite_in && reg_decode(haddr_in) == opamp_pin_share_pkg::REG_MODE)
      |=> ##1 (amp_en_q == $past(hwdata_in[0]) && amp_enable_out == $past(amp_en_q));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("Amp enable write not taken.");

   property p_pin_local;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      reset_n_in |=> (pad_oe_n_out[7:6] == ~($past(gpio_drive_in[7:6]) & ~$past(cfg_q[7:6]))
                && pad_oe_n_out[0] == ~$past(gpio_drive_in[0]));
   endproperty
   a_pin_local: assert property (p_pin_local) else $error("Other pins disturbed by config.");

   c_amp_on: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) $rose(amp_enable_out));
   c_adc_route: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) adc_amp_channel_out);
   c_pure_analog: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) !amp_en_q && cfg_q[4]);
   c_amp_off: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) $fell(amp_enable_out));
   c_cfg_read: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      take && !hwrite_in && reg_decode(haddr_in) == opamp_pin_share_pkg::REG_CFG);
endmodule

/* File: tb/pad_model.sv */
// Purpose: Pad side model for the eight port-1 pins.
// Assumes: A released pad settles to the level the bench floats onto it.
// Notes: A driven pad reads back its own output value.
`timescale 1ns/100ps
// ==========================================
// Pad loopback.
module pad_model (
   input wire logic [7:0] dout_in,
   input wire logic [7:0] oe_n_in,
   input wire logic [7:0] float_in,
   output logic [7:0] din_out
);
   // Each pad shows its driven value, or the floating level once released.
   assign din_out = (dout_in & ~oe_n_in) | (float_in & oe_n_in);
endmodule

/* File: tb/opamp_pin_share_control_tb.sv */
// Purpose: Self-checking bench for the amplifier pin-sharing block.
// Assumes: One AHB-Lite master; pads loop back through the pad model.
// Notes: Released pads float high, so a cut input path shows as a zero.
`timescale 1ns/100ps
`include "opamp_pin_share_defs.svh"
module opamp_pin_share_control_tb;
   localparam logic [31:0] MODE_A = 32'h0000_026c;
   localparam logic [31:0] CFG_A = 32'h0000_0358;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [7:0] gdout = 8'ha5, gdrive = 8'hff, pdin, pdout, poe_n, gdin, pan;
   logic [3:0] chsel = 4'h0;
   logic amp_en, amp_o, amp_p, amp_n, adc_amp;
   int err_count = 0, num_checks = 0, cyc = 0;
   // ==========================================
   // Clock, design and pad model.
   always #10 ref_clk_in = ~ref_clk_in;
   opamp_pin_share_control opamp_pin_share_control_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
      .hready_in(hreadyout), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
      .hresp_out(hresp), .gpio_dout_in(gdout), .gpio_drive_in(gdrive), .pad_din_in(pdin),
      .adc_channel_select_in(chsel), .pad_dout_out(pdout), .pad_oe_n_out(poe_n), .gpio_din_out(gdin),
      .pad_analog_out(pan), .amp_enable_out(amp_en), .amp_output_pin_out(amp_o),
      .amp_positive_pin_out(amp_p), .amp_negative_pin_out(amp_n), .adc_amp_channel_out(adc_amp));
   pad_model pad_model_inst (.dout_in(pdout), .oe_n_in(poe_n), .float_in(8'hff), .din_out(pdin));
   // ==========================================
   // Shared tasks.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One single word transfer; waits on the slave's ready in both phases.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge ref_clk_in);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge ref_clk_in); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge ref_clk_in); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk({31'h0000_0000, hresp}, 32'h0000_0000, "response");
   endtask
   // Lets register state reach the pins and the pads come back through the synchroniser.
   task automatic settle();
      repeat (5) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================
   // Scenarios.
   task automatic test_gpio();
      settle();
      chk(pdout, 8'ha5, "gpio out");
      chk(poe_n, 8'h00, "gpio oe");
      chk(gdin, 8'ha5, "gpio in");
      chk({pan, amp_en, amp_o, amp_p, amp_n}, 12'h000, "amp off");
      @(posedge ref_clk_in);
      gdrive <= 8'h0f;
      settle();
      chk(poe_n, 8'hf0, "gpio partial drive");
      chk(gdin, 8'hf5, "gpio partial in");
      @(posedge ref_clk_in);
      gdrive <= 8'hff;
      $display("test gpio done");
   endtask
   task automatic test_amp();
      bus(1'b1, MODE_A, 32'hffff_ffff);
      bus(1'b0, MODE_A, 32'h0000_0000);
      chk(rd, 32'h0000_0001, "mode readback");
      settle();
      chk(poe_n, 8'h38, "amp oe");
      chk(gdin, 8'h85, "amp in cut");
      chk(pdout, 8'h85, "amp out cut");
      chk(pan, 8'h38, "amp analog");
      chk({amp_en, amp_o, amp_p, amp_n}, 4'hf, "amp pins");
      for (int c = 0; c < 16; c++) begin
         @(posedge ref_clk_in);
         chsel <= 4'(c);
         repeat (2) @(posedge ref_clk_in);
         #1;
         chk(adc_amp, c == 11, "adc route");
      end
      bus(1'b1, MODE_A, 32'h0000_0000);
      chsel <= 4'hb;
      settle();
      chk({poe_n, pan, amp_o}, 17'h0, "amp released");
      chk(adc_amp, 1'b0, "adc route off");
      $display("test amp done");
   endtask
   task automatic test_cfg();
      for (int n = 1; n < 8; n++) begin
         bus(1'b1, CFG_A, 32'h1 << n);
         settle();
         chk(pan, 8'h1 << n, "cfg analog");
         chk(poe_n, 8'h1 << n, "cfg oe");
         chk(gdin, 8'ha5 & ~(8'h1 << n), "cfg in");
      end
      bus(1'b1, CFG_A, 32'hffff_ffff);
      bus(1'b0, CFG_A, 32'h0000_0000);
      chk(rd, 32'h0000_00fe, "cfg readback");
      bus(1'b1, 32'h0000_0100, 32'hffff_ffff);
      bus(1'b0, 32'h0000_0100, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped");
      bus(1'b1, CFG_A, 32'h0000_0000);
      settle();
      chk(poe_n, 8'h00, "cfg cleared");
      $display("test cfg done");
   endtask
   // Reset in mid-run with the amplifier on must hand the pins back to GPIO.
   task automatic test_reset();
      bus(1'b1, MODE_A, 32'h0000_0001);
      bus(1'b1, CFG_A, 32'h0000_0080);
      settle();
      chk(pan, 8'hb8, "before reset");
      @(posedge ref_clk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk({poe_n, pan, amp_en}, 17'h1fe00, "mid reset pins");
      @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, MODE_A, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "mode after reset");
      bus(1'b0, CFG_A, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "cfg after reset");
      settle();
      chk({poe_n, pan, amp_o}, 17'h0, "gpio after reset");
      chk(gdin, 8'ha5, "input after reset");
      $display("test reset done");
   endtask
   // ==========================================
   // Timeout and main sequence.
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk({poe_n, pan, amp_en}, 17'h1fe00, "reset pins");
      repeat (2) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, MODE_A, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "mode reset");
      bus(1'b0, CFG_A, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "cfg reset");
      test_gpio();
      test_amp();
      test_cfg();
      test_reset();
      complete_run();
   end
endmodule
